// file: shared/sdam_pkg.sv
// Summary of operation
// RULE_01: any alarm stops motor by assigned method
// RULE_02: selectable codes: bit0 one decelerates, zero coasts
// RULE_03: reset input on then off clears resettable
// RULE_04: power-on also clears input-resettable alarms
// RULE_05: power-cycle alarms ignore the reset input
// RULE_06: power-on self-check failure raises code 12
// RULE_07: processing task overrun raises code 13
// RULE_08: converter fault raises code 17
// RULE_09: encoder signal losses raise codes 20, 21
// RULE_10: speed deviation persisting raises code 23
// RULE_11: constant-speed deviation raises code 3F
// RULE_12: overspeed raises code 31
// RULE_13: overcurrent raises 32, overheat raises 3B
// RULE_14: illegal initial parameters raise code 37
// RULE_15: changeover faults raise codes 40, 41
// RULE_16: encoder feedback fault raises code 42
// RULE_17: motor overheat raises non-resettable code 46
// RULE_18: overload raises 50, continuous overload 51
// RULE_19: position error over limit raises 52
// RULE_20: unsupported input function raises code 57
// RULE_21: orientation error after completion raises 5C
// RULE_22: watchdog failure raises code 88
// RULE_23: display alternates axis/alarm, flickers on alarm
// RULE_24: first alarm code latched until reset
// RULE_25: initial errors raised only while stopped
package sdam_pkg;
	// number of alarm slots: 21 sources plus one unused entry
	localparam int NUM_ALARMS = 22;
	// reset classes
	typedef enum logic [1:0] {
		SDAM_INPUT_RESET,
		SDAM_POWER_CYCLE,
		SDAM_NON_RESET
	} sdam_class_t;
	// stop methods
	typedef enum logic [1:0] {
		SDAM_STOP_SELECT,
		SDAM_STOP_COAST,
		SDAM_STOP_INITIAL
	} sdam_stop_t;
	// alarm codes, in source order
	localparam logic [7:0] ALARM_CODE [NUM_ALARMS] = '{
		8'h12, 8'h13, 8'h17, 8'h20, 8'h21, 8'h23, 8'h31, 8'h32, 8'h37, 8'h3b, 8'h3f,
		8'h40, 8'h41, 8'h42, 8'h46, 8'h50, 8'h51, 8'h52, 8'h57, 8'h5c, 8'h88, 8'h00};
	// source indices used by name
	localparam int IDX_MEM = 0;
	localparam int IDX_ENC_MOTOR = 3;
	localparam int IDX_SPEED_DEV = 5;
	localparam int IDX_PARAM = 8;
	localparam int IDX_OVERHEAT = 14;
	localparam int IDX_OPTION = 18;
	// stop-method parameter bit selecting deceleration
	localparam int STOP_SEL_BIT = 0;
	// speed deviation threshold in r/min
	localparam logic [15:0] SPEED_DEV_RPM = 16'h0032;
	// time unit for deviation persistence: 1 ms
	localparam int CLK_HZ = 10000000;
	localparam int MS_NS = 1000000;
	localparam int CLK_NS = 1000000000 / CLK_HZ;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	// display alternation period in ms and flicker period in ms
	localparam int DISP_ALT_MS = 500;
	localparam int DISP_FLICK_MS = 125;
	localparam logic [15:0] MS_ONE = 16'h0001;
	localparam logic [7:0] CODE_NONE = 8'h00;
endpackage

// file: verilog/sdam_ms_tick.sv
`timescale 1ns/1ns
`default_nettype none
// divider producing a one-cycle pulse every millisecond
module sdam_ms_tick
	import sdam_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// output tick
	output logic ms_tick
);
	logic [15:0] cnt_reg; // cycle counter

	// count cycles to one millisecond
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cnt_reg <= '0;
		end else if (cnt_reg == 16'(MS_CYCLES - 1)) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + MS_ONE;
		end
	end

	// pulse on wrap
	assign ms_tick = (cnt_reg == 16'(MS_CYCLES - 1));
endmodule
`default_nettype wire

// file: verilog/sdam_top.sv
`timescale 1ns/1ns
`default_nettype none
// spindle drive alarm manager
module sdam_top
	import sdam_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// fault indications from monitoring (pins, synchronised here)
	input wire logic self_check_fail,
	input wire logic task_overrun,
	input wire logic adc_fault,
	input wire logic enc_motor_z_loss,
	input wire logic enc_machine_loss,
	input wire logic overspeed,
	input wire logic pm_overcurrent,
	input wire logic pm_overheat,
	input wire logic const_speed,
	input wire logic sel_signal_fault,
	input wire logic changeover_comm_fault,
	input wire logic enc_feedback_fault,
	input wire logic motor_overheat,
	input wire logic overload_full,
	input wire logic overload_30min,
	input wire logic orient_done,
	input wire logic watchdog_fail,
	input wire logic motor_stopped,
	// measured quantities
	input wire logic [15:0] speed_cmd,
	input wire logic [15:0] speed_fb,
	input wire logic [31:0] pos_err,
	input wire logic [31:0] orient_err,
	// parameters from the control unit
	input wire logic param_valid,
	input wire logic param_illegal,
	input wire logic [15:0] alarm_stop_method_param,
	input wire logic [15:0] dev_time_ms,
	input wire logic [15:0] dev2_amount,
	input wire logic [15:0] dev2_time_ms,
	input wire logic [31:0] pos_err_limit,
	input wire logic [31:0] orient_err_limit,
	input wire logic gp_input_unsupported,
	input wire logic [7:0] axis_number,
	// general-purpose alarm-reset input
	input wire logic alarm_reset_in,
	// stop control and status
	output logic alarm_active,
	output logic stop_coast,
	output logic stop_decel,
	output logic [7:0] alarm_code,
	output logic [NUM_ALARMS-1:0] alarm_flags,
	// front display
	output logic [7:0] disp_value,
	output logic disp_on
);
	// reset class per source
	function automatic sdam_class_t class_of(input int i);
		if (i == IDX_MEM || i == 1 || i == IDX_OPTION || i == 20) begin
			return SDAM_POWER_CYCLE;
		end else if (i >= IDX_OVERHEAT && i <= 17) begin
			return SDAM_NON_RESET;
		end else begin
			return SDAM_INPUT_RESET;
		end
	endfunction

	// stop method per source
	function automatic sdam_stop_t stop_of(input int i);
		if (i == IDX_MEM || i == 2 || i == IDX_PARAM || i == IDX_OPTION) begin
			return SDAM_STOP_INITIAL;
		end else if (i == IDX_ENC_MOTOR || i == 4 || i == IDX_OVERHEAT || i == 17) begin
			return SDAM_STOP_SELECT;
		end else begin
			return SDAM_STOP_COAST;
		end
	endfunction

	localparam int NUM_PINS = 20; // synchronised single-bit inputs
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] sync1_reg;
	logic [NUM_PINS-1:0] sync2_reg;
	logic rst_sync1_reg; // alarm-reset input synchroniser
	logic rst_sync2_reg;
	logic rst_prev_reg; // last sampled reset input
	logic reset_pulse; // on-then-off completed
	logic ms_tick;
	logic [15:0] speed_diff;
	logic [15:0] dev_cnt_reg; // persistence of speed deviation
	logic [15:0] dev2_cnt_reg; // persistence of constant-speed deviation
	logic [NUM_ALARMS-1:0] detect; // raw detect per source
	logic [NUM_ALARMS-1:0] flag_reg; // latched alarms
	logic [7:0] code_reg; // first alarm code
	logic coast_reg;
	logic decel_reg;
	logic [15:0] alt_cnt_reg; // display alternation counter, ms
	logic show_alarm_reg;
	logic flick_reg;
	logic [7:0] disp_reg;

	assign pin_raw = {motor_stopped, watchdog_fail, orient_done, overload_30min,
		overload_full, motor_overheat, enc_feedback_fault, changeover_comm_fault,
		sel_signal_fault, const_speed, pm_overheat, pm_overcurrent, overspeed,
		enc_machine_loss, enc_motor_z_loss, adc_fault, task_overrun, self_check_fail,
		param_illegal, gp_input_unsupported};

	// two-stage synchroniser for pin inputs
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			rst_sync1_reg <= alarm_reset_in;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end

	// falling edge of reset input ends the on-then-off toggle
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rst_prev_reg <= 1'b0;
		end else begin
			rst_prev_reg <= rst_sync2_reg;
		end
	end
	assign reset_pulse = rst_prev_reg && !rst_sync2_reg; // RULE_03

	// millisecond time base
	sdam_ms_tick u_tick (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.ms_tick(ms_tick)
	);

	// absolute speed difference
	assign speed_diff = (speed_cmd >= speed_fb) ? (speed_cmd - speed_fb) : (speed_fb - speed_cmd);

	// persistence counter for deviation at or above threshold
	always_ff @(posedge ref_clk) begin
		if (!rst_b || speed_diff < SPEED_DEV_RPM) begin
			dev_cnt_reg <= '0;
		end else if (ms_tick && dev_cnt_reg != 16'hffff) begin
			dev_cnt_reg <= dev_cnt_reg + MS_ONE; // RULE_10
		end
	end

	// persistence counter for constant-speed deviation
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !sync2_reg[10] || speed_diff <= dev2_amount) begin
			dev2_cnt_reg <= '0;
		end else if (ms_tick && dev2_cnt_reg != 16'hffff) begin
			dev2_cnt_reg <= dev2_cnt_reg + MS_ONE; // RULE_11
		end
	end

	// raw detection per source, in code order
	always_comb begin
		detect = '0;
		detect[0] = sync2_reg[2]; // RULE_06
		detect[1] = sync2_reg[3]; // RULE_07
		detect[2] = sync2_reg[4]; // RULE_08
		detect[3] = sync2_reg[5]; // RULE_09
		detect[4] = sync2_reg[6]; // RULE_09
		detect[5] = dev_cnt_reg > dev_time_ms; // RULE_10
		detect[6] = sync2_reg[7]; // RULE_12
		detect[7] = sync2_reg[8]; // RULE_13
		detect[8] = param_valid && sync2_reg[1]; // RULE_14
		detect[9] = sync2_reg[9]; // RULE_13
		detect[10] = dev2_cnt_reg > dev2_time_ms; // RULE_11
		detect[11] = sync2_reg[11]; // RULE_15
		detect[12] = sync2_reg[12]; // RULE_15
		detect[13] = sync2_reg[13]; // RULE_16
		detect[14] = sync2_reg[14]; // RULE_17
		detect[15] = sync2_reg[15]; // RULE_18
		detect[16] = sync2_reg[16]; // RULE_18
		detect[17] = pos_err > pos_err_limit; // RULE_19
		detect[18] = sync2_reg[0]; // RULE_20
		detect[19] = sync2_reg[17] && (orient_err > orient_err_limit); // RULE_21
		detect[20] = sync2_reg[18]; // RULE_22
	end

	// latch per alarm; set wins over clear
	generate
		for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_flag
			logic allowed;
			assign allowed = (stop_of(g) != SDAM_STOP_INITIAL) || sync2_reg[19]; // RULE_25
			always_ff @(posedge ref_clk) begin
				if (!rst_b) begin
					flag_reg[g] <= 1'b0; // RULE_04
				end else if (detect[g] && allowed) begin
					flag_reg[g] <= 1'b1;
				end else if (reset_pulse && class_of(g) == SDAM_INPUT_RESET) begin
					flag_reg[g] <= 1'b0; // RULE_03 RULE_05
				end
			end
		end
	endgenerate

	// first-alarm code: captured when no alarm latched
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			code_reg <= CODE_NONE;
		end else if (flag_reg == '0) begin
			code_reg <= CODE_NONE;
			for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
				if (detect[i] && ((stop_of(i) != SDAM_STOP_INITIAL) || sync2_reg[19])) begin
					code_reg <= ALARM_CODE[i]; // RULE_24
				end
			end
		end
	end

	// stop method: coast dominates any selectable decel
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			coast_reg <= 1'b0;
			decel_reg <= 1'b0;
		end else begin
			coast_reg <= 1'b0;
			decel_reg <= 1'b0;
			for (int i = 0; i < NUM_ALARMS; i++) begin
				if (flag_reg[i]) begin
					if (stop_of(i) == SDAM_STOP_SELECT && alarm_stop_method_param[STOP_SEL_BIT]) begin
						decel_reg <= 1'b1; // RULE_02
					end else begin
						coast_reg <= 1'b1; // RULE_01
					end
				end
			end
		end
	end

	// display alternation and flicker timing
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			alt_cnt_reg <= '0;
			show_alarm_reg <= 1'b0;
			flick_reg <= 1'b1;
		end else if (ms_tick) begin
			if (alt_cnt_reg == 16'(DISP_ALT_MS - 1)) begin
				alt_cnt_reg <= '0;
				show_alarm_reg <= !show_alarm_reg; // RULE_23
			end else begin
				alt_cnt_reg <= alt_cnt_reg + MS_ONE;
			end
			if (alt_cnt_reg % 16'(DISP_FLICK_MS) == 16'(DISP_FLICK_MS - 1)) begin
				flick_reg <= !flick_reg;
			end
		end
	end

	// display value register
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			disp_reg <= CODE_NONE;
		end else begin
			disp_reg <= (show_alarm_reg && flag_reg != '0) ? code_reg : axis_number;
		end
	end

	assign alarm_active = (flag_reg != '0);
	assign stop_coast = coast_reg;
	assign stop_decel = decel_reg && !coast_reg;
	assign alarm_code = code_reg;
	assign alarm_flags = flag_reg;
	assign disp_value = disp_reg;
	assign disp_on = (flag_reg == '0) || flick_reg; // RULE_23

	// overheat stays latched across reset input
	a_overheat_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		flag_reg[IDX_OVERHEAT] |=> flag_reg[IDX_OVERHEAT]) // RULE_17
		else $error("non-resettable alarm cleared");
	// power-cycle alarm ignores reset toggle
	a_power_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		flag_reg[IDX_MEM] && reset_pulse |=> flag_reg[IDX_MEM]) // RULE_05
		else $error("power-cycle alarm cleared by input");
	// toggle clears input-resettable alarm
	a_input_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
		reset_pulse && !detect[IDX_ENC_MOTOR] |=> !flag_reg[IDX_ENC_MOTOR]) // RULE_03
		else $error("input-resettable alarm not cleared");
	// detection latches an alarm next cycle
	a_speed_latch: assert property (@(posedge ref_clk) disable iff (!rst_b)
		detect[IDX_SPEED_DEV] |=> flag_reg[IDX_SPEED_DEV]) // RULE_10
		else $error("speed deviation not latched");
	// initial error gated by motor state
	a_initial_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!flag_reg[IDX_PARAM] && !sync2_reg[19] |=> !flag_reg[IDX_PARAM]) // RULE_25
		else $error("initial error raised while running");
	// alarm produces stop within two cycles
	sequence s_alarm_rise;
		!alarm_active ##1 alarm_active;
	endsequence
	a_alarm_stop: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_alarm_rise |-> ##[0:2] (stop_coast || stop_decel)) // RULE_01
		else $error("alarm without stop");
	// decel chosen only when selector bit set
	a_decel_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
		stop_decel |-> $past(alarm_stop_method_param[STOP_SEL_BIT])) // RULE_02
		else $error("decel without selector bit");
	// code stays while alarm latched
	a_code_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		alarm_active && $past(alarm_active) |-> $stable(alarm_code)) // RULE_24
		else $error("first alarm code changed");
endmodule
`default_nettype wire

// file: verif/sdam_nc_model.sv
`timescale 1ns/1ns
`default_nettype none
// control unit model: sends parameters after power-on and works the alarm-reset input
module sdam_nc_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// choice made by the bench
	input wire logic decel_sel,
	// parameters to the drive
	output logic param_valid,
	output logic [15:0] alarm_stop_method_param,
	output logic [15:0] dev_time_ms,
	output logic [15:0] dev2_amount,
	output logic [15:0] dev2_time_ms,
	output logic [31:0] pos_err_limit,
	output logic [31:0] orient_err_limit,
	output logic [7:0] axis_number,
	// general-purpose input set to the alarm-reset function
	output logic alarm_reset_in
);
	// bit0 picks deceleration for the selectable codes
	assign alarm_stop_method_param = {15'h0000, decel_sel};
	assign dev_time_ms = 16'h0001;
	assign dev2_amount = 16'h000a;
	assign dev2_time_ms = 16'h0001;
	assign pos_err_limit = 32'h0000_0100;
	assign orient_err_limit = 32'h0000_0100;
	assign axis_number = 8'h01;
	// reset input idle and parameters not yet sent
	initial begin
		alarm_reset_in = 1'b0;
		param_valid = 1'b0;
	end
	// parameters go valid one cycle after power-on, off edge
	always @(negedge ref_clk) begin
		param_valid <= rst_b;
	end
	// reset input turned on, held, then turned off
	task automatic pulse_reset();
		@(negedge ref_clk);
		alarm_reset_in = 1'b1;
		repeat (4) @(negedge ref_clk);
		alarm_reset_in = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: verif/tb_spindle_drive_alarm_manager.sv
`timescale 1ns/1ns
`default_nettype none
// bench: one fault source per row, then the awkward cases
module tb_spindle_drive_alarm_manager;
	import sdam_pkg::*;
	logic ref_clk, rst_b, motor_stopped, decel_sel, param_valid, alarm_reset_in;
	logic [20:0] fv; // one bit per fault source
	logic [15:0] stop_param, dev_time, dev2_amt, dev2_time;
	logic [31:0] pos_lim, ori_lim;
	logic [7:0] axis, alarm_code, disp_value;
	logic alarm_active, stop_coast, stop_decel, disp_on;
	logic [NUM_ALARMS-1:0] alarm_flags;
	int n_fail = 0;
	int num_checks = 0;
	// source, expected code, stop checked, cleared by reset input
	typedef struct {int src; logic [7:0] code; bit stp; bit clr;} sdam_row_t;
	sdam_row_t rows [21] = '{
		'{0, 8'h12, 0, 0}, '{1, 8'h13, 1, 0}, '{2, 8'h17, 0, 1}, '{3, 8'h20, 1, 1},
		'{4, 8'h21, 1, 1}, '{5, 8'h31, 1, 1}, '{6, 8'h32, 1, 1}, '{7, 8'h37, 0, 1},
		'{8, 8'h3b, 1, 1}, '{9, 8'h40, 1, 1}, '{10, 8'h41, 1, 1}, '{11, 8'h42, 1, 1},
		'{12, 8'h46, 1, 0}, '{13, 8'h50, 1, 0}, '{14, 8'h51, 1, 0}, '{15, 8'h57, 0, 0},
		'{16, 8'h88, 1, 0}, '{17, 8'h52, 1, 0}, '{18, 8'h5c, 1, 1}, '{19, 8'h3f, 1, 1},
		'{20, 8'h23, 1, 1}};
	// device under test
	sdam_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .self_check_fail(fv[0]),
		.task_overrun(fv[1]), .adc_fault(fv[2]), .enc_motor_z_loss(fv[3]),
		.enc_machine_loss(fv[4]), .overspeed(fv[5]), .pm_overcurrent(fv[6]),
		.param_illegal(fv[7]), .pm_overheat(fv[8]), .sel_signal_fault(fv[9]),
		.changeover_comm_fault(fv[10]), .enc_feedback_fault(fv[11]),
		.motor_overheat(fv[12]), .overload_full(fv[13]), .overload_30min(fv[14]),
		.gp_input_unsupported(fv[15]), .watchdog_fail(fv[16]),
		.pos_err(fv[17] ? 32'h0000_0200 : 32'h0000_0000), .orient_done(fv[18]),
		.orient_err(32'h0000_0200), .const_speed(fv[19]), .speed_cmd(16'h03e8),
		.speed_fb(fv[20] ? 16'h03ac : (fv[19] ? 16'h03d4 : 16'h03e8)),
		.motor_stopped(motor_stopped), .param_valid(param_valid),
		.alarm_stop_method_param(stop_param), .dev_time_ms(dev_time),
		.dev2_amount(dev2_amt), .dev2_time_ms(dev2_time), .pos_err_limit(pos_lim),
		.orient_err_limit(ori_lim), .axis_number(axis), .alarm_reset_in(alarm_reset_in),
		.alarm_active(alarm_active), .stop_coast(stop_coast), .stop_decel(stop_decel),
		.alarm_code(alarm_code), .alarm_flags(alarm_flags), .disp_value(disp_value),
		.disp_on(disp_on));
	// control unit partner
	sdam_nc_model i_nc (.ref_clk(ref_clk), .rst_b(rst_b), .decel_sel(decel_sel),
		.param_valid(param_valid), .alarm_stop_method_param(stop_param),
		.dev_time_ms(dev_time), .dev2_amount(dev2_amt), .dev2_time_ms(dev2_time),
		.pos_err_limit(pos_lim), .orient_err_limit(ori_lim), .axis_number(axis),
		.alarm_reset_in(alarm_reset_in));
	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// counted four-state compare
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	// wait for an alarm under a bounded count
	task automatic wait_alarm();
		int k;
		k = 0;
		@(negedge ref_clk);
		while (alarm_active !== 1'b1 && k < 40000) begin
			@(negedge ref_clk);
			k++;
		end
		chk("alarm_active raised", 32'h1, {31'h0, alarm_active});
	endtask
	// power cycle of the drive
	task automatic power_cycle();
		rst_b = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_b = 1'b1;
		@(negedge ref_clk);
	endtask
	// counts, verdict, end of run
	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (90000) @(posedge ref_clk);
		n_fail++;
		$display("mismatch watchdog expected done seen timeout");
		finish_test();
	end
	// main sequence
	initial begin
		rst_b = 1'b0;
		fv = '0;
		motor_stopped = 1'b1;
		decel_sel = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("flags in reset", 32'h1, {31'h0, alarm_flags === '0});
		chk("disp_value in reset", 32'h0, {24'h0, disp_value});
		rst_b = 1'b1;
		// each source alone: code, stop, reset class
		foreach (rows[i]) begin
			fv[rows[i].src] = 1'b1;
			wait_alarm();
			fv = '0;
			chk("alarm_code", {24'h0, rows[i].code}, {24'h0, alarm_code});
			repeat (2) @(negedge ref_clk);
			// axis shown and display steady long before the first alternation
			chk("disp_value", 32'h1, {24'h0, disp_value});
			chk("disp_on", 32'h1, {31'h0, disp_on});
			chk("one flag", 32'h1, {31'h0, $onehot(alarm_flags)});
			if (rows[i].stp) begin
				chk("stop_coast", 32'h1, {31'h0, stop_coast});
				chk("stop_decel", 32'h0, {31'h0, stop_decel});
			end
			i_nc.pulse_reset();
			repeat (6) @(negedge ref_clk);
			chk("after reset input", {31'h0, ~rows[i].clr}, {31'h0, alarm_active});
			chk("code after reset input", {24'h0, (rows[i].clr ? 8'h00 : rows[i].code)},
				{24'h0, alarm_code});
			power_cycle();
			chk("after power cycle", 32'h0, {31'h0, alarm_active});
			chk("code after power cycle", 32'h0, {24'h0, alarm_code});
			chk("coast after power cycle", 32'h0, {31'h0, stop_coast});
		end
		// selectable code decelerates; a later alarm leaves the code
		decel_sel = 1'b1;
		fv[3] = 1'b1;
		wait_alarm();
		repeat (2) @(negedge ref_clk);
		chk("stop_decel", 32'h1, {31'h0, stop_decel});
		chk("stop_coast", 32'h0, {31'h0, stop_coast});
		fv[5] = 1'b1;
		repeat (6) @(negedge ref_clk);
		chk("first code kept", 32'h20, {24'h0, alarm_code});
		chk("both flags", 32'h0000_0048, {10'h0, alarm_flags});
		fv = '0;
		decel_sel = 1'b0;
		power_cycle();
		// mid-run power cycle clears every latched alarm and the code
		chk("flags after power cycle", 32'h0, {10'h0, alarm_flags});
		chk("code cleared", 32'h0, {24'h0, alarm_code});
		chk("decel cleared", 32'h0, {31'h0, stop_decel});
		// initial error ignored while motor turns
		motor_stopped = 1'b0;
		fv[2] = 1'b1;
		fv[7] = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk("initial err running", 32'h0, {31'h0, alarm_active});
		fv = '0;
		motor_stopped = 1'b1;
		// deviation shorter than set time gives no alarm
		fv[20] = 1'b1;
		repeat (5000) @(negedge ref_clk);
		chk("short deviation", 32'h0, {31'h0, alarm_active});
		fv = '0;
		finish_test();
	end
endmodule
`default_nettype wire
